// ### pauc_pkg.sv
package pauc_pkg;
  localparam int        PAUC_MAX_DATA   = 63;  // Storage limit in bytes
  localparam int        PAUC_MAX_REPLY  = 64;  // Longest reply in characters
  localparam logic [7:0] PAUC_CH_HASH   = 8'h23;
  localparam logic [7:0] PAUC_CH_ZERO   = 8'h30;
  localparam logic [7:0] PAUC_CH_NINE   = 8'h39;
  localparam logic [7:0] PAUC_CH_LF     = 8'h0a;
  localparam logic [7:0] PAUC_LEN_DIGITS = 8'h02;  // Length digits in a data reply
  localparam logic [31:0] PAUC_PHASE_RST = 32'h0000_0000;  // Preset phase
  localparam logic [31:0] PAUC_CLK_RST   = 32'h0000_0000;  // Preset clock value
  localparam logic [3:0]  PAUC_UNIT_LEN  = 4'h3;           // Length of DEG
  localparam logic [7:0]  PAUC_CH_D      = 8'h44;
  localparam logic [7:0]  PAUC_CH_E      = 8'h45;
  localparam logic [7:0]  PAUC_CH_G      = 8'h47;
  localparam logic [7:0]  PAUC_CH_H      = 8'h48;
  localparam logic [7:0]  PAUC_CH_Z      = 8'h7a;

  // Commands already decoded from text by the front end
  typedef enum logic [2:0] {
    PAUC_CMD_PHASE_SET, PAUC_CMD_PHASE_QRY, PAUC_CMD_CLK_SET, PAUC_CMD_CLK_QRY,
    PAUC_CMD_PHASE_ZERO, PAUC_CMD_PRESET, PAUC_CMD_PUD_QRY, PAUC_CMD_NONE
  } pauc_cmd_type;

  // One decoded command with its numeric argument
  typedef struct packed {
    pauc_cmd_type cmd;
    logic [31:0]  value;  // Float bits of the argument
  } pauc_req_type;

  // One byte of the data stream with its end flag
  typedef struct packed {
    logic [7:0] data;
    logic       eoi;
  } pauc_byte_type;
endpackage

// ### pauc_block_parser.sv
`timescale 1ns/1ps
// Parses the block header and payload of a user data write
module pauc_block_parser (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   inValid,
  input  wire pauc_pkg::pauc_byte_type inByte,
  output logic                        dataValid,   // Payload byte strobe
  output logic [7:0]                  dataByte,
  output logic                        frameDone,   // Complete good frame
  output logic                        frameErr     // Header or length fault
);
  typedef enum {P_HASH, P_FORM, P_DIGITS, P_FIXED, P_OPEN, P_SKIP} pauc_pstate_type;

  pauc_pstate_type state_q, state_d;
  logic [3:0]  digLeft_q, digLeft_d;   // Count digits still to come
  logic [7:0]  count_q,   count_d;     // Bytes still to come or declared
  logic [7:0]  got_q,     got_d;       // Bytes received in open form
  logic        dv_d, fd_d, fe_d;
  logic [7:0]  db_d;
  logic [9:0]  countWide;              // Count before saturation, holds 64 * 10 + 9

  // Digit test shared by both header fields
  function automatic logic isDigit(input logic [7:0] c);
    return (c >= pauc_pkg::PAUC_CH_ZERO) && (c <= pauc_pkg::PAUC_CH_NINE);
  endfunction

  // Next state of the parser
  always_comb begin
    state_d = state_q;
    digLeft_d = digLeft_q;
    count_d = count_q;
    got_d = got_q;
    dv_d = 1'b0;
    fd_d = 1'b0;
    fe_d = 1'b0;
    db_d = inByte.data;
    countWide = 10'h000;
    if (inValid) begin
      unique case (state_q)
        P_HASH: begin
          if (inByte.data == pauc_pkg::PAUC_CH_HASH) begin
            state_d = P_FORM;
          end else begin
            fe_d = 1'b1;
            state_d = P_SKIP;
          end
        end
        P_FORM: begin
          count_d = 8'h00;
          got_d = 8'h00;
          if (inByte.data == pauc_pkg::PAUC_CH_ZERO) begin
            state_d = P_OPEN;
          end else if (isDigit(inByte.data)) begin
            digLeft_d = 4'(inByte.data - pauc_pkg::PAUC_CH_ZERO);
            state_d = P_DIGITS;
          end else begin
            fe_d = 1'b1;
            state_d = P_SKIP;
          end
        end
        P_DIGITS: begin
          // Saturate so very long counts are still caught as too long
          if (!isDigit(inByte.data)) begin
            fe_d = 1'b1;
            state_d = P_SKIP;
          end else begin
            // Wide sum so a long count can not wrap back into the legal range
            countWide = 10'(count_q) * 10'h00a + 10'(inByte.data - pauc_pkg::PAUC_CH_ZERO);
            count_d = (countWide > 10'(pauc_pkg::PAUC_MAX_DATA)) ?
                      8'(pauc_pkg::PAUC_MAX_DATA + 1) : countWide[7:0];
            digLeft_d = digLeft_q - 4'h1;
            if (digLeft_q == 4'h1) begin
              if (count_d > 8'(pauc_pkg::PAUC_MAX_DATA)) begin
                fe_d = 1'b1;
                state_d = P_SKIP;
              end else if (count_d == 8'h00) begin
                fd_d = 1'b1;
                state_d = P_HASH;
              end else begin
                state_d = P_FIXED;
              end
            end
          end
        end
        P_FIXED: begin
          dv_d = 1'b1;
          count_d = count_q - 8'h01;
          if (count_q == 8'h01) begin
            fd_d = 1'b1;
            state_d = P_HASH;
          end
        end
        P_OPEN: begin
          if (inByte.eoi && inByte.data == pauc_pkg::PAUC_CH_LF) begin
            fd_d = 1'b1;
            state_d = P_HASH;
          end else if (got_q == 8'(pauc_pkg::PAUC_MAX_DATA)) begin
            fe_d = 1'b1;
            state_d = inByte.eoi ? P_HASH : P_SKIP;
          end else begin
            dv_d = 1'b1;
            got_d = got_q + 8'h01;
          end
        end
        P_SKIP: begin
          // Drop the rest of a bad message up to its end
          if (inByte.eoi) begin
            state_d = P_HASH;
          end
        end
      endcase
    end
  end

  // Parser registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= P_HASH;
      digLeft_q <= 4'h0;
      count_q <= 8'h00;
      got_q <= 8'h00;
      dataValid <= 1'b0;
      dataByte <= 8'h00;
      frameDone <= 1'b0;
      frameErr <= 1'b0;
    end else begin
      state_q <= state_d;
      digLeft_q <= digLeft_d;
      count_q <= count_d;
      got_q <= got_d;
      dataValid <= dv_d;
      dataByte <= db_d;
      frameDone <= fd_d;
      frameErr <= fe_d;
    end
  end
endmodule

// ### pauc_cmd_core.sv
`timescale 1ns/1ps
// Command core: phase settings, preset and protected user data store
module pauc_cmd_core (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    reqValid,    // Decoded command strobe
  input  wire pauc_pkg::pauc_req_type  req,
  input  wire logic                    pudValid,    // User data write byte strobe
  input  wire pauc_pkg::pauc_byte_type pudByte,
  input  wire logic                    calSwitchPin, // Rear calibration switch
  input  wire logic                    sweepActive,  // Sweep running, same clock
  input  wire logic                    replyReady,
  output logic                         replyValid,
  output logic [7:0]                   replyText,   // Unit or block reply chars
  output logic [31:0]                  replyValue,  // Float value of a query
  output logic                         replyValueValid,
  output logic [31:0]                  phaseOut,    // Relative phase setting
  output logic [31:0]                  phaseClkOut, // Phase clock frequency
  output logic                         presetPulse, // Tells others to preset
  output logic                         cmdError,    // Refused or bad command
  output logic                         busy
);
  typedef enum {S_IDLE, S_UNIT, S_HDR, S_NDIG, S_LEN1, S_LEN2, S_DATA} pauc_rstate_type;

  logic [7:0]  mem [pauc_pkg::PAUC_MAX_DATA];  // Non volatile user data image
  logic [5:0]  len_q, len_d;                    // Stored byte count
  logic [5:0]  wptr_q, wptr_d;                  // Write pointer of a frame
  logic [5:0]  idx_q, idx_d;                    // Reply index
  logic [31:0] phase_q, phase_d;
  logic [31:0] clk_q, clk_d;
  logic        isHz_q, isHz_d;                  // Unit string selector
  pauc_rstate_type st_q, st_d;
  logic        calS1_q, calS2_q;                // Switch synchroniser
  logic        err_d, pre_d, vv_d;
  logic [31:0] rv_q, rv_d;
  logic        pDv, pDone, pErr;
  logic [7:0]  pByte;
  logic        wrOk;
  logic [7:0]  ch;

  // Header and payload parser for the write stream
  pauc_block_parser u_parser (
    .mclk      (mclk),
    .rst       (rst),
    .inValid   (pudValid),
    .inByte    (pudByte),
    .dataValid (pDv),
    .dataByte  (pByte),
    .frameDone (pDone),
    .frameErr  (pErr)
  );

  // Switch comes from a panel pin, so it is synchronised first
  always_ff @(posedge mclk) begin
    if (rst) begin
      calS1_q <= 1'b0;
      calS2_q <= 1'b0;
    end else begin
      calS1_q <= calSwitchPin;
      calS2_q <= calS1_q;
    end
  end

  assign wrOk = calS2_q;

  // Payload bytes go straight into mem; length commits only on a good end
  always_ff @(posedge mclk) begin
    if (pDv && wrOk && wptr_q < 6'(pauc_pkg::PAUC_MAX_DATA)) begin
      mem[wptr_q] <= pByte;
    end
  end

  // Character that the reply walk puts out
  always_comb begin
    ch = 8'h00;
    unique case (st_q)
      S_UNIT: begin
        if (isHz_q) begin
          ch = (idx_q == 6'h0) ? pauc_pkg::PAUC_CH_H : pauc_pkg::PAUC_CH_Z;
        end else begin
          ch = (idx_q == 6'h0) ? pauc_pkg::PAUC_CH_D :
               (idx_q == 6'h1) ? pauc_pkg::PAUC_CH_E : pauc_pkg::PAUC_CH_G;
        end
      end
      S_HDR:  ch = pauc_pkg::PAUC_CH_HASH;
      S_NDIG: ch = pauc_pkg::PAUC_CH_ZERO + pauc_pkg::PAUC_LEN_DIGITS;
      S_LEN1: ch = pauc_pkg::PAUC_CH_ZERO + 8'(len_q / 6'd10);
      S_LEN2: ch = pauc_pkg::PAUC_CH_ZERO + 8'(len_q % 6'd10);
      S_DATA: ch = mem[idx_q];
      S_IDLE: ch = 8'h00;
    endcase
  end

  assign replyValid = (st_q != S_IDLE);
  assign replyText = ch;
  assign busy = (st_q != S_IDLE);

  // Next values of settings, store and reply walk
  always_comb begin
    phase_d = phase_q;
    clk_d = clk_q;
    len_d = len_q;
    wptr_d = wptr_q;
    idx_d = idx_q;
    isHz_d = isHz_q;
    st_d = st_q;
    err_d = 1'b0;
    pre_d = 1'b0;
    vv_d = 1'b0;
    rv_d = rv_q;
    if (pDv && wrOk) begin
      wptr_d = wptr_q + 6'h1;
    end
    if (pDone) begin
      wptr_d = 6'h0;
      if (wrOk) begin
        len_d = wptr_q + (pDv ? 6'h1 : 6'h0);
      end else begin
        err_d = 1'b1;
      end
    end
    if (pErr) begin
      wptr_d = 6'h0;
      err_d = 1'b1;
    end
    if (reqValid && st_q == S_IDLE) begin
      unique case (req.cmd)
        pauc_pkg::PAUC_CMD_PHASE_SET: begin
          if (sweepActive) err_d = 1'b1;
          else phase_d = req.value;
        end
        pauc_pkg::PAUC_CMD_PHASE_ZERO: begin
          if (sweepActive) err_d = 1'b1;
          else phase_d = pauc_pkg::PAUC_PHASE_RST;
        end
        pauc_pkg::PAUC_CMD_CLK_SET: begin
          if (sweepActive || !wrOk) err_d = 1'b1;
          else clk_d = req.value;
        end
        pauc_pkg::PAUC_CMD_PHASE_QRY, pauc_pkg::PAUC_CMD_CLK_QRY: begin
          isHz_d = (req.cmd == pauc_pkg::PAUC_CMD_CLK_QRY);
          rv_d = isHz_d ? clk_q : phase_q;
          vv_d = 1'b1;
          idx_d = 6'h0;
          st_d = S_UNIT;
        end
        pauc_pkg::PAUC_CMD_PRESET: begin
          phase_d = pauc_pkg::PAUC_PHASE_RST;
          clk_d = pauc_pkg::PAUC_CLK_RST;
          pre_d = 1'b1;
        end
        pauc_pkg::PAUC_CMD_PUD_QRY: begin
          idx_d = 6'h0;
          st_d = S_HDR;
        end
        default: ;  // No command: an error flagged by the parser still stands
      endcase
    end
    if (replyReady && st_q != S_IDLE) begin
      unique case (st_q)
        S_UNIT: begin
          idx_d = idx_q + 6'h1;
          if (idx_q == (isHz_q ? 6'h1 : 6'(pauc_pkg::PAUC_UNIT_LEN - 4'h1))) st_d = S_IDLE;
        end
        // Hash, count digit, two length digits, data: a full 63 byte store
        // would run past 64 characters, so hosts keep stored data to 60 bytes
        S_HDR:  st_d = S_NDIG;
        S_NDIG: st_d = S_LEN1;
        S_LEN1: st_d = S_LEN2;
        S_LEN2: st_d = (len_q == 6'h0) ? S_IDLE : S_DATA;
        S_DATA: begin
          idx_d = idx_q + 6'h1;
          if (idx_q + 6'h1 == len_q) st_d = S_IDLE;
        end
        S_IDLE: st_d = S_IDLE;
      endcase
    end
  end

  // Header digit count: always two length digits
  // (hash, digit 2, two digits, data)

  // State registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_q <= pauc_pkg::PAUC_PHASE_RST;
      clk_q <= pauc_pkg::PAUC_CLK_RST;
      len_q <= 6'h0;
      wptr_q <= 6'h0;
      idx_q <= 6'h0;
      isHz_q <= 1'b0;
      st_q <= S_IDLE;
      rv_q <= 32'h0000_0000;
      replyValueValid <= 1'b0;
      presetPulse <= 1'b0;
      cmdError <= 1'b0;
    end else begin
      phase_q <= phase_d;
      clk_q <= clk_d;
      len_q <= len_d;
      wptr_q <= wptr_d;
      idx_q <= idx_d;
      isHz_q <= isHz_d;
      st_q <= st_d;
      rv_q <= rv_d;
      replyValueValid <= vv_d;
      presetPulse <= pre_d;
      cmdError <= err_d;
    end
  end

  assign replyValue = rv_q;
  assign phaseOut = phase_q;
  assign phaseClkOut = clk_q;
endmodule

// ### pauc_cmd_core_assertions.sv
`timescale 1ns/1ps
// Port-level checks of the command core
module pauc_cmd_core_assertions (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   reqValid,
  input wire pauc_pkg::pauc_req_type req,
  input wire logic                   calSwitchPin,
  input wire logic                   sweepActive,
  input wire logic                   busy,
  input wire logic                   replyValid,
  input wire logic [7:0]             replyText,
  input wire logic [31:0]            replyValue,
  input wire logic                   replyValueValid,
  input wire logic [31:0]            phaseOut,
  input wire logic [31:0]            phaseClkOut,
  input wire logic                   presetPulse,
  input wire logic                   cmdError
);
  logic       take;      // Request taken this edge
  logic [2:0] swCnt_q;   // Cycles the switch level has held
  logic [2:0] swCnt_d;
  logic       swLast_q;  // Switch level one cycle ago
  logic       swOk;      // Sync lag is over, switch level trusted
  assign take = reqValid && !busy;
  assign swOk = swCnt_q >= 3'h4;
  // Saturating count; a change restarts it since the sync flops still lag
  always_comb begin
    swCnt_d = swCnt_q + {2'h0, swCnt_q != 3'h7};
    if (calSwitchPin != swLast_q) begin
      swCnt_d = 3'h0;
    end
  end
  // Registers only
  always_ff @(posedge mclk) begin
    swCnt_q  <= rst ? 3'h0 : swCnt_d;
    swLast_q <= calSwitchPin;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  chk_zero_clear: assert property (
    take && req.cmd == pauc_pkg::PAUC_CMD_PHASE_ZERO && !sweepActive
    |=> phaseOut == 32'h0000_0000 && !cmdError) else $error("phase zero kept phase");
  chk_zero_sweep: assert property (
    take && req.cmd == pauc_pkg::PAUC_CMD_PHASE_ZERO && sweepActive
    |=> cmdError && $stable(phaseOut)) else $error("phase zero taken in sweep");
  chk_adj_sweep: assert property (
    take && req.cmd == pauc_pkg::PAUC_CMD_PHASE_SET && sweepActive
    |=> cmdError && $stable(phaseOut)) else $error("phase set taken in sweep");
  chk_clk_store: assert property (
    take && req.cmd == pauc_pkg::PAUC_CMD_CLK_SET && !sweepActive && calSwitchPin && swOk
    |=> phaseClkOut == $past(req.value) && !cmdError) else $error("clock value not kept");
  chk_clk_refuse: assert property (
    take && req.cmd == pauc_pkg::PAUC_CMD_CLK_SET && (sweepActive || !calSwitchPin && swOk)
    |=> cmdError && $stable(phaseClkOut)) else $error("clock set not refused");
  chk_phase_reply: assert property (
    take && req.cmd == pauc_pkg::PAUC_CMD_PHASE_QRY |=> replyValueValid && replyValid
    && replyValue == $past(phaseOut) && replyText == pauc_pkg::PAUC_CH_D)
    else $error("phase reply wrong");
  chk_clk_reply: assert property (
    take && req.cmd == pauc_pkg::PAUC_CMD_CLK_QRY |=> replyValueValid && replyValid
    && replyValue == $past(phaseClkOut) && replyText == pauc_pkg::PAUC_CH_H)
    else $error("clock reply wrong");
  chk_preset_all: assert property (
    take && req.cmd == pauc_pkg::PAUC_CMD_PRESET |=> presetPulse
    && phaseOut == pauc_pkg::PAUC_PHASE_RST && phaseClkOut == pauc_pkg::PAUC_CLK_RST)
    else $error("preset incomplete");
  chk_pud_header: assert property (
    take && req.cmd == pauc_pkg::PAUC_CMD_PUD_QRY |=> replyValid
    && replyText == pauc_pkg::PAUC_CH_HASH) else $error("data reply header wrong");
  cover property (take && req.cmd == pauc_pkg::PAUC_CMD_PUD_QRY);
  cover property (take && req.cmd == pauc_pkg::PAUC_CMD_CLK_SET && sweepActive);
  cover property (cmdError);
endmodule
bind pauc_cmd_core pauc_cmd_core_assertions u_pauc_cmd_core_assertions (
  .mclk, .rst, .reqValid, .req, .calSwitchPin, .sweepActive, .busy, .replyValid,
  .replyText, .replyValue, .replyValueValid, .phaseOut, .phaseClkOut, .presetPulse,
  .cmdError);

// ### pauc_ctl_model.sv
`timescale 1ns/1ps
// Controller side: takes reply characters, promptly or with stalls
module pauc_ctl_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       slow,        // Stall on alternate cycles
  input  wire logic       clr,         // Forget earlier replies
  input  wire logic       replyValid,
  input  wire logic [7:0] replyText,
  output logic            replyReady
);
  logic [7:0] got [0:127];  // Characters taken, read by the bench
  int         n = 0;        // Count of characters taken
  // A char is taken only at an edge where both sides agree
  always @(posedge mclk) begin
    if (rst) begin
      replyReady <= 1'b0;
    end else begin
      if (clr) begin
        n <= 0;
      end else if (replyValid && replyReady) begin
        got[n[6:0]] <= replyText;
        n           <= n + 1;
      end
      replyReady <= slow ? !replyReady : 1'b1;
    end
  end
endmodule

// ### phase_and_user_data_cmds_tb.sv
`timescale 1ns/1ps
// Bench of the command core
module phase_and_user_data_cmds_tb;
  typedef struct {
    pauc_pkg::pauc_cmd_type cmd;
    logic [31:0] val;
    logic sw;
    logic err;
    logic [31:0] ph;
    logic [31:0] ck;
  } pauc_row_type;
  logic                    mclk, rst, reqValid, pudValid, calSwitchPin, sweepActive;
  logic                    slow, clr, errSeen, replyReady, replyValid, replyValueValid;
  logic                    presetPulse, cmdError, busy;
  pauc_pkg::pauc_req_type  req;
  pauc_pkg::pauc_byte_type pudByte;
  logic [7:0]              replyText;
  logic [31:0]             replyValue, phaseOut, phaseClkOut;
  int                      failures = 0;
  int                      n_tests = 0;
  int                      cycles = 0;
  // Command, argument, sweep, then error, phase and clock expected
  pauc_row_type rows [9] = '{
    '{pauc_pkg::PAUC_CMD_CLK_SET, 32'h0000_04d2, 1'b0, 1'b0, 32'h0, 32'h0000_04d2},
    '{pauc_pkg::PAUC_CMD_CLK_SET, 32'h0000_0037, 1'b1, 1'b1, 32'h0, 32'h0000_04d2},
    '{pauc_pkg::PAUC_CMD_PHASE_SET, 32'h42b4_0000, 1'b1, 1'b1, 32'h0, 32'h0000_04d2},
    '{pauc_pkg::PAUC_CMD_PHASE_SET, 32'h42b4_0000, 1'b0, 1'b0, 32'h42b4_0000, 32'h4d2},
    '{pauc_pkg::PAUC_CMD_PHASE_ZERO, 32'h0, 1'b1, 1'b1, 32'h42b4_0000, 32'h0000_04d2},
    '{pauc_pkg::PAUC_CMD_PHASE_ZERO, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0000_04d2},
    '{pauc_pkg::PAUC_CMD_NONE, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0000_04d2},
    '{pauc_pkg::PAUC_CMD_PHASE_SET, 32'h4234_0000, 1'b0, 1'b0, 32'h4234_0000, 32'h4d2},
    '{pauc_pkg::PAUC_CMD_PRESET, 32'h0, 1'b0, 1'b0, 32'h0, 32'h0}};
  pauc_cmd_core u_pauc_cmd_core (
    .mclk, .rst, .reqValid, .req, .pudValid, .pudByte, .calSwitchPin, .sweepActive,
    .replyReady, .replyValid, .replyText, .replyValue, .replyValueValid, .phaseOut,
    .phaseClkOut, .presetPulse, .cmdError, .busy);
  pauc_ctl_model u_pauc_ctl_model (
    .mclk, .rst, .slow, .clr, .replyValid, .replyText, .replyReady);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Error pulses are short, so keep them until the next request or write frame
  always @(posedge mclk) begin
    errSeen <= (rst || clr) ? 1'b0 : errSeen | (cmdError === 1'b1);
    cycles  <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  task automatic test_done();
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Requests go in only when idle, since one reply runs at a time
  task automatic idle();
    int k;
    k = 0;
    #1;
    while (busy !== 1'b0 && k < 300) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask
  task automatic issue(pauc_pkg::pauc_cmd_type c, logic [31:0] v);
    idle();
    @(posedge mclk);
    reqValid <= 1'b1;
    req      <= '{c, v};
    clr      <= 1'b1;
    @(posedge mclk);
    reqValid <= 1'b0;
    clr      <= 1'b0;
    #1;
  endtask
  task automatic qry(pauc_pkg::pauc_cmd_type c, logic [31:0] v, string s);
    issue(c, 32'h0);
    if (c != pauc_pkg::PAUC_CMD_PUD_QRY) begin
      check("replyValue", replyValue, v);
    end
    idle();
    check("reply length", u_pauc_ctl_model.n, s.len());
    for (int i = 0; i < s.len(); i++) begin
      check("reply char", 32'(u_pauc_ctl_model.got[i]), 32'(s[i]));
    end
  endtask
  // Whole frame back to back, end flag on its last byte
  task automatic send(string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge mclk);
      pudValid <= 1'b1;
      clr      <= i == 0;
      pudByte  <= '{s[i], i == s.len() - 1};
    end
    @(posedge mclk);
    pudValid <= 1'b0;
    clr      <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
  endtask
  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    req = '{pauc_pkg::PAUC_CMD_NONE, 32'h0};
    pudValid = 1'b0;
    pudByte = '{8'h00, 1'b0};
    calSwitchPin = 1'b1;
    sweepActive = 1'b0;
    slow = 1'b0;
    clr = 1'b0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check("reset phase", phaseOut, 32'h0);
    check("reset clock", phaseClkOut, 32'h0);
    check("reset busy", 32'(busy), 32'h0);
    foreach (rows[i]) begin
      @(posedge mclk);
      sweepActive <= rows[i].sw;
      issue(rows[i].cmd, rows[i].val);
      repeat (2) @(posedge mclk);
      #1;
      check("cmdError", 32'(errSeen), 32'(rows[i].err));
      check("phaseOut", phaseOut, rows[i].ph);
      check("phaseClkOut", phaseClkOut, rows[i].ck);
    end
    sweepActive <= 1'b0;
    issue(pauc_pkg::PAUC_CMD_PHASE_SET, 32'h4234_0000);
    issue(pauc_pkg::PAUC_CMD_CLK_SET, 32'h0000_04d2);
    qry(pauc_pkg::PAUC_CMD_PHASE_QRY, 32'h4234_0000, "DEG");
    slow <= 1'b1;
    qry(pauc_pkg::PAUC_CMD_CLK_QRY, 32'h0000_04d2, "Hz");
    slow <= 1'b0;
    send("#15ABCDE");
    check("write error", 32'(errSeen), 32'h0);
    qry(pauc_pkg::PAUC_CMD_PUD_QRY, 32'h0, "#205ABCDE");
    send("#0XY\n");
    qry(pauc_pkg::PAUC_CMD_PUD_QRY, 32'h0, "#202XY");
    calSwitchPin <= 1'b0;
    send("#11Q");
    check("locked write", 32'(errSeen), 32'h1);
    issue(pauc_pkg::PAUC_CMD_CLK_SET, 32'h0000_0099);
    repeat (2) @(posedge mclk);
    #1;
    check("locked clock", 32'(errSeen), 32'h1);
    check("locked clock", phaseClkOut, 32'h0000_04d2);
    calSwitchPin <= 1'b1;
    send("#1AQ");
    check("bad digit", 32'(errSeen), 32'h1);
    send("#264Z");
    check("too long", 32'(errSeen), 32'h1);
    qry(pauc_pkg::PAUC_CMD_PUD_QRY, 32'h0, "#202XY");
    // Reset again mid-run: settings and stored length must clear
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    check("second reset phase", phaseOut, 32'h0);
    check("second reset clock", phaseClkOut, 32'h0);
    check("second reset busy", 32'(busy), 32'h0);
    qry(pauc_pkg::PAUC_CMD_PUD_QRY, 32'h0, "#200");
    test_done();
  end
endmodule
